// ==== hw/cpl_protect.sv ====
// per-cycle protection, current limiting, thermal and power-good logic
// assumes comparator flags arrive asynchronously and a switching clock pulse input
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - overvoltage turns low-side on to discharge
// - overvoltage persisting repeats discharge next cycle
// - reverse limit: both off till next cycle
// - reverse limit in discharge: both off till next cycle
// - peak comparator masked after high-side on
// - valley comparator masked after low-side on
// - reverse limit acts while valley masked
// - peak trip ends on-time, not below minimum
// - valley high ignores new switching edges
// - over-temperature stops all switching
// - restart after thermal only via soft-start
// - power-good low when feedback under 90%
// - power-good low when above 120% 10us
// - power-good low during soft-start
// - power-good low on thermal or undervoltage
// - power-good pin is open drain
module cpl_protect
    import cpl_pkg::*;
#(
    parameter int PG_FILTER = cpl_pkg::PG_FILTER_CYC,
    parameter int PK_MASK   = cpl_pkg::PK_MASK_CYC,
    parameter int VY_MASK   = cpl_pkg::VY_MASK_CYC,
    parameter int TON_MIN   = cpl_pkg::TON_MIN_CYC
) (
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic       swClkPulse,
    input  wire logic       dutyEnd,
    input  wire logic       softStartDone,
    input  wire logic       overvoltageFlag,
    input  wire logic       peakCurrentFlag,
    input  wire logic       valleyCurrentFlag,
    input  wire logic       reverseCurrentFlag,
    input  wire logic       thermalTripFlag,
    input  wire logic       undervoltageFlag,
    input  wire logic       feedbackLowFlag,
    input  wire logic       feedbackHighFlag,
    input  wire logic [3:0] regAddr,
    input  wire logic [7:0] regWdata,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    output logic [7:0]      regRdata,
    output logic            highSideSwitch,
    output logic            lowSideSwitch,
    output logic            softStartRequest,
    output logic            regulationFlagOut,
    output logic            regulationFlagOe_n,
    output logic            irq
);
    import cpl_pkg::*;

    localparam int NF = 8;
    localparam int MW = 8;

    // ==========================================================
    // input synchronisers
    logic [NF-1:0] syncA;
    logic [NF-1:0] syncB;
    logic          ovp, pk, vy, rev, hot, input_undervoltage_lockout, fbLo, fbHi;
    // flags come from the analog side, so they pass two flops first
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            syncA <= '0;
            syncB <= '0;
        end else begin
            syncA <= {feedbackHighFlag, feedbackLowFlag, undervoltageFlag, thermalTripFlag,
                      reverseCurrentFlag, valleyCurrentFlag, peakCurrentFlag, overvoltageFlag};
            syncB <= syncA;
        end
    end
    assign {fbHi, fbLo, input_undervoltage_lockout, hot, rev, vy, pk, ovp} = syncB;

    // ==========================================================
    // control register and phase machine
    logic       runEnable;
    cpl_phase_t phase;
    cpl_phase_t next_phase;
    logic [MW-1:0] phaseCnt;
    logic       thermLatch;
    logic       ssWait;
    logic       peakTrip;
    logic       valleyBlock;
    logic       stop;

    // masking windows run from each switch turn-on
    assign peakTrip    = (phase == PH_HIGH) && pk && (phaseCnt >= MW'(PK_MASK))
                         && (phaseCnt >= MW'(TON_MIN));
    assign valleyBlock = (phase == PH_LOW) && vy && (phaseCnt >= MW'(VY_MASK));
    assign stop        = hot || thermLatch || ssWait || !runEnable || input_undervoltage_lockout;

    // next phase: protections outrank the normal switching cycle
    always_comb begin
        next_phase = phase;
        unique case (phase)
            PH_IDLE: begin
                if (!stop && swClkPulse) begin
                    next_phase = ovp ? PH_SINK : PH_HIGH;
                end
            end
            PH_HIGH: begin
                if (stop) begin
                    next_phase = PH_IDLE;
                end else if (ovp) begin
                    next_phase = PH_SINK;
                end else if (peakTrip || (dutyEnd && phaseCnt >= MW'(TON_MIN))) begin
                    next_phase = PH_LOW;
                end
            end
            PH_LOW: begin
                if (stop) begin
                    next_phase = PH_IDLE;
                end else if (rev) begin
                    next_phase = PH_OFF;
                end else if (swClkPulse && !valleyBlock) begin
                    next_phase = ovp ? PH_SINK : PH_HIGH;
                end
            end
            PH_SINK: begin
                if (stop) begin
                    next_phase = PH_IDLE;
                end else if (rev) begin
                    next_phase = PH_OFF;
                end else if (swClkPulse) begin
                    next_phase = ovp ? PH_SINK : PH_HIGH;
                end
            end
            PH_OFF: begin
                if (stop) begin
                    next_phase = PH_IDLE;
                end else if (swClkPulse) begin
                    next_phase = ovp ? PH_SINK : PH_HIGH;
                end
            end
        endcase
    end

    // phase register and turn-on timer
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            phase    <= PH_IDLE;
            phaseCnt <= '0;
        end else begin
            phase <= next_phase;
            if (next_phase != phase) begin
                phaseCnt <= '0;
            end else if (phaseCnt != '1) begin
                phaseCnt <= phaseCnt + 1'b1;
            end
        end
    end

    // gate commands from flops; never both on
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            highSideSwitch <= 1'b0;
            lowSideSwitch  <= 1'b0;
        end else begin
            highSideSwitch <= (next_phase == PH_HIGH);
            lowSideSwitch  <= (next_phase == PH_LOW) || (next_phase == PH_SINK);
        end
    end

    // ==========================================================
    // thermal latch and soft-start handshake
    // the sensor supplies the hysteresis; logic only sees the clean flag
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            thermLatch <= 1'b0;
            ssWait     <= 1'b1;
        end else begin
            if (hot) begin
                thermLatch <= 1'b1;
            end else if (thermLatch) begin
                thermLatch <= 1'b0;
            end
            if (hot || input_undervoltage_lockout || !runEnable) begin
                ssWait <= 1'b1;
            end else if (softStartDone) begin
                ssWait <= 1'b0;
            end
        end
    end
    assign softStartRequest = ssWait && !hot && !input_undervoltage_lockout && runEnable;

    // ==========================================================
    // power-good window and pin
    logic fbLoHeld;
    logic fbHiHeld;
    logic pgPull;

    cpl_filter #(.COUNT(PG_FILTER)) u_lowFilt (
        .core_clk (core_clk),
        .rstn     (rstn),
        .level    (fbLo),
        .held     (fbLoHeld)
    );
    cpl_filter #(.COUNT(PG_FILTER)) u_highFilt (
        .core_clk (core_clk),
        .rstn     (rstn),
        .level    (fbHi),
        .held     (fbHiHeld)
    );

    // registered so the pin never glitches on comparator chatter
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pgPull <= 1'b1;
        end else begin
            pgPull <= fbLoHeld || fbHiHeld || ssWait || hot || thermLatch || input_undervoltage_lockout;
        end
    end
    assign regulationFlagOut  = 1'b0;
    assign regulationFlagOe_n = !pgPull;

    // ==========================================================
    // interrupt status, mask and register port
    logic [EV_N-1:0] status;
    logic [EV_N-1:0] mask;
    logic [EV_N-1:0] events;
    logic            pgPrev;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pgPrev <= 1'b1;
        end else begin
            pgPrev <= pgPull;
        end
    end

    always_comb begin
        events           = '0;
        events[EV_OVP]   = ovp && (next_phase == PH_SINK) && (phase != PH_SINK);
        events[EV_REV]   = (next_phase == PH_OFF) && (phase != PH_OFF);
        events[EV_PEAK]  = peakTrip;
        events[EV_SKIP]  = swClkPulse && valleyBlock;
        events[EV_THERM] = hot && !thermLatch;
        events[EV_PGLOW] = pgPull && !pgPrev;
    end

    // a read clears status, but an event in that cycle still sets
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            status <= '0;
        end else if (regRead && regAddr == REG_STATUS) begin
            status <= events;
        end else begin
            status <= status | events;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mask      <= MASK_RST;
            runEnable <= CTRL_RST[0];
        end else if (regWrite) begin
            if (regAddr == REG_MASK) begin
                mask <= regWdata[EV_N-1:0];
            end
            if (regAddr == REG_CTRL) begin
                runEnable <= regWdata[CTRL_RUN];
            end
        end
    end

    // read data valid the cycle after the strobe; unmapped reads zero
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            regRdata <= '0;
        end else if (regRead) begin
            unique case (regAddr)
                REG_STATUS: regRdata <= {2'h0, status};
                REG_MASK:   regRdata <= {2'h0, mask};
                REG_CTRL:   regRdata <= {7'h00, runEnable};
                REG_STATE:  regRdata <= {pgPull, ssWait, thermLatch, phase};
                default:    regRdata <= 8'h00;
            endcase
        end else begin
            regRdata <= 8'h00;
        end
    end

    assign irq = |(status & mask);

    // ==========================================================
    // checks
    AST_OVP_SINK: assert property (@(posedge core_clk) disable iff (!rstn)
        (phase == PH_HIGH && ovp && !stop) |=> lowSideSwitch && !highSideSwitch)
        else $error("overvoltage did not turn low side on");
    AST_REPEAT: assert property (@(posedge core_clk) disable iff (!rstn)
        (phase == PH_OFF && swClkPulse && ovp && !stop) |=> phase == PH_SINK)
        else $error("overvoltage discharge not repeated");
    sequence s_revTrip;
        phase == PH_LOW && rev && !stop;
    endsequence
    AST_REV_OFF: assert property (@(posedge core_clk) disable iff (!rstn)
        s_revTrip ##1 !swClkPulse |=> !highSideSwitch && !lowSideSwitch)
        else $error("switches not off after reverse limit");
    AST_SINK_REV: assert property (@(posedge core_clk) disable iff (!rstn)
        (phase == PH_SINK && rev && !stop) |=> phase == PH_OFF)
        else $error("reverse limit in discharge not handled");
    AST_PK_MASK: assert property (@(posedge core_clk) disable iff (!rstn)
        (phase == PH_HIGH && phaseCnt < MW'(PK_MASK) && !dutyEnd && !ovp && !stop) |=> highSideSwitch)
        else $error("peak trip inside mask");
    AST_VY_MASK: assert property (@(posedge core_clk) disable iff (!rstn)
        (phase == PH_LOW && phaseCnt < MW'(VY_MASK) && swClkPulse && !rev && !ovp && !stop) |=> highSideSwitch)
        else $error("valley block inside mask");
    AST_TON_MIN: assert property (@(posedge core_clk) disable iff (!rstn)
        (phase == PH_HIGH && phaseCnt < MW'(TON_MIN) && !ovp && !stop) |=> highSideSwitch)
        else $error("on-time below minimum");
    AST_PEAK_END: assert property (@(posedge core_clk) disable iff (!rstn)
        (peakTrip && !ovp && !stop) |=> !highSideSwitch)
        else $error("peak trip did not end on-time");
    AST_SKIP: assert property (@(posedge core_clk) disable iff (!rstn)
        (valleyBlock && !rev && !stop) |=> !highSideSwitch)
        else $error("clock edge taken during valley block");
    AST_THERM: assert property (@(posedge core_clk) disable iff (!rstn)
        hot |=> ##1 !highSideSwitch && !lowSideSwitch)
        else $error("switching during thermal shutdown");
    AST_PG_SS: assert property (@(posedge core_clk) disable iff (!rstn)
        ssWait |=> !regulationFlagOe_n)
        else $error("power good released in soft-start");
    AST_PG_FAULT: assert property (@(posedge core_clk) disable iff (!rstn)
        (hot || input_undervoltage_lockout) |=> ##1 !regulationFlagOe_n)
        else $error("power good released on fault");
    AST_PG_LOW: assert property (@(posedge core_clk) disable iff (!rstn)
        fbLoHeld |=> !regulationFlagOe_n)
        else $error("power good released while feedback low");
    AST_PG_HIGH: assert property (@(posedge core_clk) disable iff (!rstn)
        fbHiHeld |=> !regulationFlagOe_n)
        else $error("power good released while feedback high");
    AST_RESTART: assert property (@(posedge core_clk) disable iff (!rstn)
        ssWait |=> !highSideSwitch && !lowSideSwitch)
        else $error("switching before soft-start done");
endmodule : cpl_protect
`default_nettype wire

// ==== hw/cpl_pkg.sv ====
// shared constants for the converter protection logic
// assumes a 40 MHz core clock and comparator flags from the analog front end
package cpl_pkg;
    // ==========================================================
    // clock and timing
    localparam int CLK_MHZ          = 40;
    localparam int PG_FILTER_NS     = 10000;                       // window filter, 10 us
    localparam int PG_FILTER_CYC    = (PG_FILTER_NS * CLK_MHZ) / 1000;
    localparam int PK_MASK_NS       = 390;                         // peak blanking after turn-on
    localparam int PK_MASK_CYC      = (PK_MASK_NS * CLK_MHZ + 999) / 1000;
    localparam int VY_MASK_NS       = 200;                         // valley minimum off-time mask
    localparam int VY_MASK_CYC      = (VY_MASK_NS * CLK_MHZ + 999) / 1000;
    localparam int TON_MIN_NS       = 100;                         // minimum on-time
    localparam int TON_MIN_CYC      = (TON_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int THERM_HYST_DEGC  = 30;                          // hysteresis lives in the sensor
    // ==========================================================
    // interrupt status bit positions
    localparam int EV_OVP   = 0;
    localparam int EV_REV   = 1;
    localparam int EV_PEAK  = 2;
    localparam int EV_SKIP  = 3;
    localparam int EV_THERM = 4;
    localparam int EV_PGLOW = 5;
    localparam int EV_N     = 6;
    localparam logic [EV_N-1:0] MASK_RST = 6'h00;
    // ==========================================================
    // register offsets and reset values
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_MASK   = 4'h1;
    localparam logic [3:0] REG_CTRL   = 4'h2;
    localparam logic [3:0] REG_STATE  = 4'h3;
    localparam logic [0:0] CTRL_RST   = 1'h0;
    localparam int         CTRL_RUN   = 0;
    // ==========================================================
    // phase state machine
    typedef enum logic [4:0] {
        PH_IDLE = 5'h01,
        PH_HIGH = 5'h02,
        PH_LOW  = 5'h04,
        PH_SINK = 5'h08,
        PH_OFF  = 5'h10
    } cpl_phase_t;
endpackage : cpl_pkg

// ==== hw/cpl_filter.sv ====
// persistence filter: output rises after input held high for a count
// assumes input already synchronised to core_clk
`timescale 1ns/100ps
`default_nettype none
module cpl_filter #(
    parameter int COUNT = 400
) (
    input  wire logic core_clk,
    input  wire logic rstn,
    input  wire logic level,
    output logic      held
);
    localparam int W = $clog2(COUNT + 1);
    logic [W-1:0] cnt;
    // ==========================================================
    // count while high, clear on any drop
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cnt  <= '0;
            held <= 1'b0;
        end else if (!level) begin
            cnt  <= '0;
            held <= 1'b0;
        end else if (cnt >= W'(COUNT)) begin
            held <= 1'b1;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end
endmodule : cpl_filter
`default_nettype wire

// ==== testbench/cpl_power_stage.sv ====
// power stage model: current flags from switch timing, pulled-up power-good pin
// assumes gate commands and the open-drain enable come from the protection block
`timescale 1ns/100ps
`default_nettype none
module cpl_power_stage (
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic       highSideSwitch,
    input  wire logic       lowSideSwitch,
    input  wire logic       regulationFlagOut,
    input  wire logic       regulationFlagOe_n,
    input  wire logic [7:0] pkDelay,
    input  wire logic [7:0] vyHold,
    input  wire logic [7:0] revDelay,
    output logic            peakCurrentFlag,
    output logic            valleyCurrentFlag,
    output logic            reverseCurrentFlag,
    output logic            regulationPin
);
    logic [7:0] hsCnt;
    logic [7:0] lsCnt;
    // ==========================================================
    // conduction time per switch, saturating so long phases never wrap
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            hsCnt <= 8'h00;
            lsCnt <= 8'h00;
        end else begin
            hsCnt <= !highSideSwitch ? 8'h00 : (hsCnt == 8'hfe ? hsCnt : hsCnt + 8'h01);
            lsCnt <= !lowSideSwitch ? 8'h00 : (lsCnt == 8'hfe ? lsCnt : lsCnt + 8'h01);
        end
    end
    // current ramps while a switch conducts; a peak delay of 8'hff never trips
    assign peakCurrentFlag    = highSideSwitch && pkDelay != 8'hff && hsCnt >= pkDelay;
    assign valleyCurrentFlag  = lowSideSwitch && lsCnt < vyHold;
    assign reverseCurrentFlag = lowSideSwitch && revDelay != 8'h00 && lsCnt >= revDelay;
    // pull-up: a released pin reads high, never the last driven value
    assign regulationPin = regulationFlagOe_n ? 1'b1 : regulationFlagOut;
endmodule : cpl_power_stage
`default_nettype wire

// ==== testbench/tb.sv ====
// self-checking bench for the converter protection logic
// assumes cpl_pkg and the power stage model; flags are driven on rising edges
`timescale 1ns/100ps
`default_nettype none
module tb;
    import cpl_pkg::*;
    localparam int PGF = 8;
    logic       core_clk;
    logic       rstn;
    logic       swClkPulse;
    logic       dutyEnd;
    logic       softStartDone;
    logic       overvoltageFlag;
    logic       thermalTripFlag;
    logic       undervoltageFlag;
    logic       feedbackLowFlag;
    logic       feedbackHighFlag;
    logic [3:0] regAddr;
    logic [7:0] regWdata;
    logic       regWrite;
    logic       regRead;
    logic [7:0] pkDelay;
    logic [7:0] vyHold;
    logic [7:0] revDelay;
    wire logic [7:0] regRdata;
    wire logic  hs;
    wire logic  ls;
    wire logic  ssReq;
    wire logic  pgOut;
    wire logic  pgOe_n;
    wire logic  irq;
    wire logic  pk;
    wire logic  vy;
    wire logic  rev;
    wire logic  pgPin;
    int         nErrors = 0;
    int         comparisons = 0;
    int         n;
    logic [7:0] d;
    cpl_protect #(.PG_FILTER(PGF)) dut (.core_clk(core_clk), .rstn(rstn), .swClkPulse(swClkPulse),
        .dutyEnd(dutyEnd), .softStartDone(softStartDone), .overvoltageFlag(overvoltageFlag),
        .peakCurrentFlag(pk), .valleyCurrentFlag(vy), .reverseCurrentFlag(rev),
        .thermalTripFlag(thermalTripFlag), .undervoltageFlag(undervoltageFlag),
        .feedbackLowFlag(feedbackLowFlag), .feedbackHighFlag(feedbackHighFlag), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .highSideSwitch(hs), .lowSideSwitch(ls), .softStartRequest(ssReq),
        .regulationFlagOut(pgOut), .regulationFlagOe_n(pgOe_n), .irq(irq));
    cpl_power_stage stage (.core_clk(core_clk), .rstn(rstn), .highSideSwitch(hs), .lowSideSwitch(ls),
        .regulationFlagOut(pgOut), .regulationFlagOe_n(pgOe_n), .pkDelay(pkDelay), .vyHold(vyHold),
        .revDelay(revDelay), .peakCurrentFlag(pk), .valleyCurrentFlag(vy),
        .reverseCurrentFlag(rev), .regulationPin(pgPin));
    // ==========================================================
    // shared helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            nErrors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk
    task automatic chkb(input logic c, input string msg);
        chk({7'h00, c}, 8'h01, msg);
    endtask : chkb
    // settle one ns past the edge so the design's updates have landed
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask : tick
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge core_clk);
        regAddr <= a;
        regWdata <= v;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1;
        v = regRdata;
    endtask : rd
    task automatic chkStat(input logic [7:0] m, input string msg);
        rd(REG_STATUS, d);
        chk(d & m, m, msg);
    endtask : chkStat
    task automatic waitGate(input logic [1:0] g, input int lim);
        n = 0;
        while ({hs, ls} !== g && n < lim) begin
            tick(1);
            n++;
        end
    endtask : waitGate
    task automatic waitPg(input logic v, input int lim);
        n = 0;
        while (pgOe_n !== v && n < lim) begin
            tick(1);
            n++;
        end
    endtask : waitPg
    task automatic pulseSw();
        @(posedge core_clk);
        swClkPulse <= 1'b1;
        @(posedge core_clk);
        swClkPulse <= 1'b0;
        #1;
    endtask : pulseSw
    task automatic pulseSs();
        @(posedge core_clk);
        softStartDone <= 1'b1;
        @(posedge core_clk);
        softStartDone <= 1'b0;
    endtask : pulseSs
    task automatic startCycle();
        pulseSw();
        waitGate(2'b10, 8);
        chkb(n < 8, "high side start");
    endtask : startCycle
    task automatic toLow();
        @(posedge core_clk);
        dutyEnd <= 1'b1;
        waitGate(2'b01, 20);
        @(posedge core_clk);
        dutyEnd <= 1'b0;
    endtask : toLow
    // ==========================================================
    // scenarios
    task automatic t_reset();
        chk({6'h00, hs, ls}, 8'h00, "gates idle");
        chkb(!pgPin, "pin low at start");
        rd(REG_STATE, d);
        chk(d & 8'h5f, 8'h41, "state after reset");
        rd(4'h9, d);
        chk(d, 8'h00, "unmapped read");
        wr(REG_MASK, 8'h3f);
        wr(REG_CTRL, 8'h01);
        tick(PGF + 6);
        chkb(!pgOe_n, "pg held in soft start");
        pulseSs();
        waitPg(1'b1, 20);
        chkb(n < 20, "pg released");
        chkb(pgPin, "pin released high");
        $display("test reset done");
    endtask : t_reset
    task automatic t_cycle();
        @(posedge core_clk);
        dutyEnd <= 1'b1;
        startCycle();
        waitGate(2'b01, 20);
        chkb(n >= TON_MIN_CYC - 1 && n <= TON_MIN_CYC + 4, "minimum on-time");
        @(posedge core_clk);
        dutyEnd <= 1'b0;
        @(posedge core_clk);
        pkDelay <= 8'h00;
        startCycle();
        waitGate(2'b01, 40);
        chkb(n >= PK_MASK_CYC - 1 && n <= PK_MASK_CYC + 5, "peak masked then trips");
        pkDelay <= 8'hff;
        tick(2);
        chkb(irq, "irq on peak");
        wr(REG_MASK, 8'h00);
        tick(1);
        chkb(!irq, "irq masked");
        wr(REG_MASK, 8'h3f);
        chkStat(8'h01 << EV_PEAK, "peak status");
        tick(1);
        chkb(!irq, "irq cleared");
        $display("test cycle done");
    endtask : t_cycle
    task automatic t_valley();
        @(posedge core_clk);
        vyHold <= 8'd40;
        startCycle();
        toLow();
        startCycle();
        toLow();
        tick(15);
        pulseSw();
        waitGate(2'b10, 12);
        chkb(n == 12, "clock skipped");
        chkStat(8'h01 << EV_SKIP, "skip status");
        vyHold <= 8'h00;
        tick(2);
        startCycle();
        toLow();
        $display("test valley done");
    endtask : t_valley
    task automatic t_ovp();
        startCycle();
        @(posedge core_clk);
        overvoltageFlag <= 1'b1;
        waitGate(2'b01, 8);
        chkb(n < 8, "discharge via low side");
        @(posedge core_clk);
        revDelay <= 8'd3;
        waitGate(2'b00, 8);
        chkb(n < 8, "reverse limit opens low side");
        tick(6);
        chk({6'h00, hs, ls}, 8'h00, "both off till clock");
        revDelay <= 8'h00;
        pulseSw();
        waitGate(2'b01, 8);
        chkb(n < 8, "discharge repeated");
        chkStat(8'h01 << EV_OVP | 8'h01 << EV_REV, "ovp and reverse status");
        overvoltageFlag <= 1'b0;
        tick(3);
        startCycle();
        toLow();
        $display("test overvoltage done");
    endtask : t_ovp
    task automatic t_therm();
        @(posedge core_clk);
        thermalTripFlag <= 1'b1;
        waitGate(2'b00, 8);
        chkb(n < 8, "switching stopped");
        waitPg(1'b0, 6);
        chkb(n < 6, "pg pulled on thermal");
        pulseSw();
        tick(8);
        chk({6'h00, hs, ls}, 8'h00, "clock ignored hot");
        thermalTripFlag <= 1'b0;
        tick(4);
        pulseSw();
        tick(8);
        chk({6'h00, hs, ls}, 8'h00, "no restart without soft start");
        chkb(ssReq, "soft start requested");
        chkStat(8'h01 << EV_THERM, "thermal status");
        pulseSs();
        startCycle();
        toLow();
        $display("test thermal done");
    endtask : t_therm
    task automatic t_pg();
        waitPg(1'b1, 20);
        chkb(n < 20, "pg back");
        @(posedge core_clk);
        feedbackLowFlag <= 1'b1;
        tick(PGF - 3);
        feedbackLowFlag <= 1'b0;
        waitPg(1'b0, 10);
        chkb(n == 10, "short dip filtered");
        for (int k = 0; k < 3; k++) begin
            @(posedge core_clk);
            {undervoltageFlag, feedbackHighFlag, feedbackLowFlag} <= 3'b001 << k;
            waitPg(1'b0, PGF + 8);
            chkb(k == 2 ? n < 6 : (n >= PGF && n < PGF + 8), "pg pull delay");
            {undervoltageFlag, feedbackHighFlag, feedbackLowFlag} <= 3'b000;
            if (k == 2) begin
                tick(2);
                pulseSs();
            end
            waitPg(1'b1, PGF + 8);
            chkb(n < PGF + 8, "pg release");
        end
        chkStat(8'h01 << EV_PGLOW, "pg fall status");
        $display("test power good done");
    endtask : t_pg
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, nErrors);
        if (nErrors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run
    // ==========================================================
    // clock, watchdog well past the few hundred cycles the tests take
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        nErrors++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        complete_run();
    end
    initial begin
        rstn = 1'b0;
        swClkPulse = 1'b0;
        dutyEnd = 1'b0;
        softStartDone = 1'b0;
        overvoltageFlag = 1'b0;
        thermalTripFlag = 1'b0;
        undervoltageFlag = 1'b0;
        feedbackLowFlag = 1'b0;
        feedbackHighFlag = 1'b0;
        regAddr = 4'h0;
        regWdata = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        pkDelay = 8'hff;
        vyHold = 8'h00;
        revDelay = 8'h00;
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        tick(1);
        t_reset();
        t_cycle();
        t_valley();
        t_ovp();
        t_therm();
        t_pg();
        complete_run();
    end
endmodule : tb
`default_nettype wire
